// ---- hdl/gpa_regs.svh ----
`ifndef GPA_REGS_SVH
`define GPA_REGS_SVH

`define GPA_NPORT        14
`define GPA_ADDR_W       8
`define GPA_BANK_OUT     2'h0
`define GPA_BANK_DIR     2'h1
`define GPA_BANK_PULL    2'h2
`define GPA_BANK_IN      2'h3
`define GPA_BANK_LSB     6
`define GPA_PORT_LSB     2
`define GPA_RESP_OKAY    2'h0
`define GPA_RESP_SLVERR  2'h2
`define GPA_RST_OUT      8'h00
`define GPA_RST_DIR      8'h00
`define GPA_RST_PULL     8'h00
`define GPA_PORT_PULL_BIT 8'h01
// per-port masks, port 13 in the top byte (top bit for the 14-bit selects), port 0 in the bottom byte (bottom bit)
`define GPA_PIN_MASK     112'h03ff000f3fff07ffffffffffff7f
`define GPA_OUT_MASK     112'h03ff000f3fff07ffffffffff007f
`define GPA_PULL_BIT_MASK 112'h00ff000f00ff07000000ffff007f
`define GPA_PULL_PORT_SEL 14'h0070
`define GPA_OD_SEL       14'h0200

`endif

// ---- hdl/gpa_pkg.sv ----
`include "gpa_regs.svh"

package gpa_pkg;

  typedef logic [`GPA_NPORT-1:0][7:0] gpa_bank_t;

  typedef struct packed {
    gpa_bank_t               out_q;
    gpa_bank_t               dir_q;
    gpa_bank_t               pull_q;
    gpa_bank_t               in_q;
    logic                    aw_got;
    logic                    w_got;
    logic [`GPA_ADDR_W-1:0]  awaddr;
    logic [7:0]              wdata;
    logic                    wstrb0;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } gpa_state_t;

endpackage : gpa_pkg

// ---- hdl/gpa_port_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none

module gpa_port_ctrl
#(
  parameter logic [7:0] OUT_MASK  = 8'hff,
  parameter logic [7:0] PULL_BITS = 8'h00,
  parameter logic       PULL_PORT = 1'b0,
  parameter logic       OPEN_DRAIN = 1'b0
)
(
  input  wire logic [7:0] out_q,
  input  wire logic [7:0] dir_q,
  input  wire logic [7:0] pull_q,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe,
  output logic      [7:0] pull_en
);

  logic [7:0] drive;
  logic [7:0] pull_sel;

  assign drive = dir_q & OUT_MASK;

  // open drain: a zero pulls low, a one releases the pin
  assign pin_out = OPEN_DRAIN ? 8'h00 : (out_q & drive);
  assign pin_oe  = OPEN_DRAIN ? (drive & ~out_q) : drive;

  // whole-port enable fans out to every OUT_MASK pin of the port
  assign pull_sel = PULL_PORT ? {8{pull_q[0]}} & OUT_MASK
                              : pull_q & PULL_BITS;

  // pull-up only on pins that are inputs
  assign pull_en = pull_sel & ~drive;

endmodule : gpa_port_ctrl

`default_nettype wire

// ---- hdl/gpa_top.sv ----
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "gpa_regs.svh"

module gpa_top
(
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       ce,
  input  wire logic [`GPA_ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [`GPA_ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire gpa_pkg::gpa_bank_t         pin_in,
  output gpa_pkg::gpa_bank_t              pin_out,
  output gpa_pkg::gpa_bank_t              pin_oe,
  output gpa_pkg::gpa_bank_t              pull_en
);
  import gpa_pkg::*;

  localparam logic [111:0] PIN_MASK  = `GPA_PIN_MASK;
  localparam logic [111:0] OUT_MASK  = `GPA_OUT_MASK;
  localparam logic [111:0] PULL_BITS = `GPA_PULL_BIT_MASK;
  localparam logic [13:0]  PULL_PORT = `GPA_PULL_PORT_SEL;
  localparam logic [13:0]  OD_SEL    = `GPA_OD_SEL;

  gpa_state_t st;
  gpa_state_t next_st;

  // address decode: valid flag, bank and port index
  function automatic logic [6:0] decode
  (
    input logic [`GPA_ADDR_W-1:0] addr
  );
    logic [3:0] port;
    logic       ok;
    port = addr[`GPA_BANK_LSB-1:`GPA_PORT_LSB];
    ok   = (port < 4'(`GPA_NPORT)) && (PIN_MASK[8*port +: 8] != 8'h00);
    decode = {ok, addr[`GPA_BANK_LSB+1:`GPA_BANK_LSB], port};
  endfunction : decode

  // mask of writable bits for one port of one bank
  function automatic logic [7:0] wmask
  (
    input logic [1:0] bank,
    input logic [3:0] port
  );
    case (bank)
      `GPA_BANK_OUT:  wmask = OUT_MASK[8*port +: 8];
      `GPA_BANK_DIR:  wmask = OUT_MASK[8*port +: 8];
      `GPA_BANK_PULL: wmask = PULL_PORT[port] ? `GPA_PORT_PULL_BIT
                                              : PULL_BITS[8*port +: 8];
      default:        wmask = 8'h00;
    endcase
  endfunction : wmask

  logic [6:0] wdec;
  logic [6:0] rdec;

  assign wdec = decode(st.awaddr);
  assign rdec = decode(s_axi_araddr);

  assign s_axi_awready = ~st.aw_got & ~st.bvalid;
  assign s_axi_wready  = ~st.w_got & ~st.bvalid;
  assign s_axi_arready = ~st.rvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  always_comb
  begin
    logic [7:0] m;
    logic [7:0] v;
    m = 8'h00;
    v = 8'h00;
    next_st = st;
    for (int p = 0; p < `GPA_NPORT; p++)
    begin
      next_st.in_q[p] = pin_in[p] & PIN_MASK[8*p +: 8];
    end
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_st.w_got  = 1'b1;
      next_st.wdata  = s_axi_wdata[7:0];
      next_st.wstrb0 = s_axi_wstrb[0];
    end
    if (st.aw_got && st.w_got)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = wdec[6] ? `GPA_RESP_OKAY : `GPA_RESP_SLVERR;
      m = wmask(wdec[5:4], wdec[3:0]);
      v = st.wdata & m;
      if (wdec[6] && st.wstrb0)
      begin
        case (wdec[5:4])
          `GPA_BANK_OUT:  next_st.out_q[wdec[3:0]]  = v;
          `GPA_BANK_DIR:  next_st.dir_q[wdec[3:0]]  = v;
          `GPA_BANK_PULL: next_st.pull_q[wdec[3:0]] = v;
          default:        next_st.bvalid = 1'b1;
        endcase
      end
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = rdec[6] ? `GPA_RESP_OKAY : `GPA_RESP_SLVERR;
      next_st.rdata  = 32'h0;
      if (rdec[6])
      begin
        case (rdec[5:4])
          `GPA_BANK_OUT:  next_st.rdata[7:0] = st.out_q[rdec[3:0]];
          `GPA_BANK_DIR:  next_st.rdata[7:0] = st.dir_q[rdec[3:0]];
          `GPA_BANK_PULL: next_st.rdata[7:0] = st.pull_q[rdec[3:0]];
          default:        next_st.rdata[7:0] = st.in_q[rdec[3:0]];
        endcase
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st        <= '0;
      st.out_q  <= {`GPA_NPORT{`GPA_RST_OUT}};
      st.dir_q  <= {`GPA_NPORT{`GPA_RST_DIR}};
      st.pull_q <= {`GPA_NPORT{`GPA_RST_PULL}};
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  // one pin driver per port
  generate
    for (genvar g = 0; g < `GPA_NPORT; g++)
    begin : g_port
      gpa_port_ctrl
      #(
        .OUT_MASK   (OUT_MASK[8*g +: 8]),
        .PULL_BITS  (PULL_BITS[8*g +: 8]),
        .PULL_PORT  (PULL_PORT[g]),
        .OPEN_DRAIN (OD_SEL[g])
      )
      u_port
      (
        .out_q   (st.out_q[g]),
        .dir_q   (st.dir_q[g]),
        .pull_q  (st.pull_q[g]),
        .pin_out (pin_out[g]),
        .pin_oe  (pin_oe[g]),
        .pull_en (pull_en[g])
      );
    end
  endgenerate

endmodule : gpa_top

`default_nettype wire

// ---- sim/gpa_pins.sv ----
`timescale 1ns/10ps
`default_nettype none

module gpa_pins
(
  input  wire logic               aclk,
  input  wire gpa_pkg::gpa_bank_t pin_out,
  input  wire gpa_pkg::gpa_bank_t pin_oe,
  input  wire gpa_pkg::gpa_bank_t pull_en,
  input  wire gpa_pkg::gpa_bank_t ext_val,
  input  wire gpa_pkg::gpa_bank_t ext_en,
  output gpa_pkg::gpa_bank_t      pin_in
);
  import gpa_pkg::*;
  gpa_bank_t last = '0;
  // driver wins, then outside drive, then pull-up, else floating toggles
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
    (~pin_oe & ~ext_en & (pull_en | ~last));
  always @(posedge aclk) last <= pin_in;
endmodule : gpa_pins

`default_nettype wire

// ---- sim/gpa_top_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "gpa_regs.svh"

module gpa_top_monitor
(
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               ce,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire gpa_pkg::gpa_bank_t pin_out,
  input wire gpa_pkg::gpa_bank_t pin_oe,
  input wire gpa_pkg::gpa_bank_t pull_en
);
  import gpa_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    ce && s_axi_arvalid && s_axi_arready;
  endsequence
  // both halves are latched at the taking edge, the answer one edge later
  a_write_answer: assert property (wr_taken |=> ##1 s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response missing");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_pull_input_only: assert property ((pull_en & pin_oe) == '0)
    else $error("pull-up on driven pin");
  a_od_port: assert property (pin_out[9] == 8'h00
    && pull_en[9] == 8'h00 && pin_oe[9][7:6] == 2'h0)
    else $error("port 9 not open drain");
  a_input_port: assert property (pin_oe[1] == 8'h00
    && (pin_oe & ~`GPA_PIN_MASK) == '0)
    else $error("absent or input pin driven");
  for (genvar g = 4; g < 7; g++)
  begin : grp
    a_port_pull_group: assert property (pull_en[g] == 8'h00
      || (pull_en[g] | pin_oe[g]) == 8'hff)
      else $error("port pull-up split");
  end
  a_reset_clear: assert property (disable iff (1'b0)
    !aresetn && ce |=> pin_oe == '0 && pull_en == '0)
    else $error("reset left pins active");
endmodule : gpa_top_monitor

bind gpa_top gpa_top_monitor mon_u (.*);

`default_nettype wire

// ---- sim/gpa_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module gpa_top_tb;
  import gpa_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  gpa_bank_t   pin_in, pin_out, pin_oe, pull_en, ext_val = '0, ext_en = '0;
  int          fails = 0, comparisons = 0;

  gpa_top dut_u (.*);
  gpa_pins pins_u (.*);
  always #2.5 aclk = ~aclk;

  task automatic results;
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [111:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
    logic aw = 1'b0;
    logic w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) aw = 1'b1;
      if (s_axi_wready === 1'b1) w = 1'b1;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask : wr

  task automatic rd(input logic [7:0] a, e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rresp", er, s_axi_rresp);
    chk("rdata", e, s_axi_rdata);
  endtask : rd

  initial
  begin
    #20000;
    fails++;
    results();
  end

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk("pin_oe", '0, pin_oe | pull_en);
    for (int p = 0; p < 14; p++)
    begin
      rd(8'(8'h40 + 4 * p), 8'h00, p == 11 ? 2'h2 : 2'h0);
      rd(8'(8'h80 + 4 * p), 8'h00, p == 11 ? 2'h2 : 2'h0);
    end
    wr(8'h40, 8'h05, 2'h0);
    wr(8'h00, 8'h01, 2'h0);
    chk("pin_oe0", 8'h05, pin_oe[0]);
    chk("pin_out0", 8'h01, pin_out[0] & pin_oe[0]);
    wr(8'h88, 8'hff, 2'h0);
    wr(8'h48, 8'h0f, 2'h0);
    chk("pull_en2", 8'hf0, pull_en[2]);
    wr(8'h90, 8'h03, 2'h0);
    rd(8'h90, 8'h01, 2'h0);
    wr(8'h50, 8'h0f, 2'h0);
    chk("pull_en45", 16'h00f0, {pull_en[5], pull_en[4]});
    wr(8'h64, 8'hff, 2'h0);
    rd(8'h64, 8'h3f, 2'h0);
    wr(8'h24, 8'h2a, 2'h0);
    wr(8'ha4, 8'hff, 2'h0);
    rd(8'ha4, 8'h00, 2'h0);
    chk("pin9", 16'h1500, {pin_oe[9], pin_out[9]});
    ext_val[9] <= 8'h3f;
    ext_en[9] <= 8'hff;
    wr(8'h80, 8'h7f, 2'h0);
    rd(8'he4, 8'h2a, 2'h0);
    rd(8'hc0, 8'h7b, 2'h0);
    wr(8'h3c, 8'hff, 2'h2);
    // clock enable low: a standing read request must not be taken
    ce <= 1'b0;
    s_axi_araddr <= 8'h90;
    s_axi_arvalid <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("rvalid_frozen", '0, s_axi_rvalid);
    ce <= 1'b1;
    s_axi_arvalid <= 1'b0;
    rd(8'h90, 8'h01, 2'h0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk("pin_oe", '0, pin_oe | pull_en);
    results();
  end
endmodule : gpa_top_tb

`default_nettype wire
